//--- logic/can_tx_priority_history.v
// can_tx_priority_history.v: tx search, completion flags and tx history list
// assumes a protocol engine next to it that takes tx_start_o and reports done/abort
//
// Behaviour
// [R1] candidate needs in-use, tx type, ready, request
// [R2] search sends highest priority pending buffer
// [R3] new higher request wins; started frame finishes
// [R4] lowest id bits 28..18 wins first
// [R5] standard data frame beats remote and extended
// [R6] standard identifier beats extended identifier
// [R7] extended ties broken by lowest id 17..0
// [R8] identical identifiers: lowest buffer number wins
// [R9] block trigger requests one buffer of 0..7
// [R10] success clears sender's request flag
// [R11] success sets done status if buffer enabled
// [R12] irq needs global and buffer enable
// [R13] software clears ready before editing buffer
// [R14] seven-entry history with write, read pointers
// [R15] history contents undefined after mode change
// [R16] last-out reads entry before write pointer
// [R17] record buffer number, then advance write pointer
// [R18] get read returns oldest, advances read pointer
// [R19] match set when pointers equal, cleared on record
// [R20] overflow at write equals read minus one
// [R21] overflow sticky; match kept while overflow set
// [R22] block group data frames not recorded
// [R23] pointers wrap modulo seven
`timescale 1ns/100ps
`include "can_tx_defs.vh"

module can_tx_priority_history (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg tx_start_o,
    output reg [3:0] tx_buf_o,
    output reg [28:0] tx_id_o,
    output reg tx_ide_o,
    output reg tx_rtr_o,
    input wire tx_done_i,
    input wire tx_abort_i,
    output reg tx_done_irq_o
);

    localparam ST_IDLE = 2'h0;
    localparam ST_SEARCH = 2'h1;
    localparam ST_BUSY = 2'h2;

    reg [5:0] cfg_q [0:15];
    reg [28:0] id_q [0:15];
    reg [2:0] ctrl_q [0:15];
    reg [3:0] hist_q [0:6];
    reg [2:0] wr_ptr_q;
    reg [2:0] rd_ptr_q;
    reg match_q;
    reg ovf_q;
    reg done_status_q;
    reg irq_en_q;
    reg abt_mode_q;
    reg abt_trig_q;
    reg [2:0] abt_ptr_q;
    reg [1:0] state_q;
    reg [3:0] cur_q;

    wire req = cyc_i & stb_i & ~ack_o;
    wire wr = req & we_i & sel_i[0];
    wire rd = req & ~we_i;
    wire [3:0] idx = adr_i[5:2];
    wire [1:0] grp = adr_i[7:6];

    // write decodes per register group
    wire wr_cfg = wr && (grp == 2'h0);
    wire wr_id = wr && (grp == 2'h1);
    wire wr_ctrl = wr && (grp == 2'h2);
    wire wr_status = wr && (adr_i == `OFF_INT_STATUS);
    wire wr_ienable = wr && (adr_i == `OFF_INT_ENABLE);
    wire wr_abt = wr && (adr_i == `OFF_ABT_CTRL);
    wire wr_get = wr && (adr_i == `OFF_HIST_GET);

    // candidate flags per buffer
    wire [15:0] cand;
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : g_cand
            assign cand[g] = cfg_q[g][`CFG_IN_USE]
                & (cfg_q[g][`CFG_TYPE_HI:`CFG_TYPE_LO] == `TYPE_TX)
                & ctrl_q[g][`CTRL_RDY] & ctrl_q[g][`CTRL_TRQ]; // [R1]
        end
    endgenerate

    // priority key: lower wins
    function [30:0] prio_key;
        input [28:0] id;
        input ide;
        input rtr;
        begin
            // std data < std remote < ext data < ext remote, then ext low bits [R4] [R5] [R6] [R7]
            if (ide)
                prio_key = {id[28:18], 1'b1, rtr, id[17:0]};
            else
                prio_key = {id[28:18], 1'b0, rtr, 18'h0};
        end
    endfunction

    reg best_ok;
    reg [3:0] best_buf;
    reg [30:0] best_key;
    reg [30:0] k;
    integer i;
    always @* begin
        best_ok = 1'b0;
        best_buf = 4'h0;
        best_key = 31'h0;
        k = 31'h0;
        for (i = 0; i < 16; i = i + 1) begin
            k = prio_key(id_q[i], cfg_q[i][`CFG_IDE], cfg_q[i][`CFG_RTR]);
            // strict compare keeps lowest buffer number on ties [R8]
            if (cand[i] && (!best_ok || k < best_key)) begin
                best_ok = 1'b1;
                best_buf = i[3:0];
                best_key = k;
            end
        end
    end

    wire cur_ie = ctrl_q[cur_q][`CTRL_IE];
    wire cur_abt = abt_mode_q && (cur_q <= `ABT_LAST);
    wire [2:0] wr_inc = (wr_ptr_q == 3'h6) ? 3'h0 : wr_ptr_q + 3'h1; // [R23]
    wire [2:0] rd_inc = (rd_ptr_q == 3'h6) ? 3'h0 : rd_ptr_q + 3'h1; // [R23]
    wire [2:0] rd_dec = (rd_ptr_q == 3'h0) ? 3'h6 : rd_ptr_q - 3'h1;
    wire [2:0] wr_dec = (wr_ptr_q == 3'h0) ? 3'h6 : wr_ptr_q - 3'h1;
    wire success = (state_q == ST_BUSY) && tx_done_i;
    wire record = success && !(cur_abt && !cfg_q[cur_q][`CFG_RTR]); // [R22]
    wire get_rd = rd && (adr_i == `OFF_HIST_GET);
    wire ovf_clr = wr_get && !dat_i[`GET_OVF];

    // overflowed list rewrites the newest entry [R20]
    wire [2:0] hist_wa = ovf_q ? wr_dec : wr_ptr_q;

    // block trigger request for the buffer at the block pointer
    wire abt_set = abt_mode_q && abt_trig_q && (state_q == ST_IDLE)
        && !ctrl_q[abt_ptr_q][`CTRL_TRQ] && ctrl_q[abt_ptr_q][`CTRL_RDY];

    // control write to the buffer on the wire
    wire ctrl_hold = (state_q == ST_BUSY) && (cur_q == idx);

    // completion interrupt condition
    wire irq_fire = success && cur_ie && irq_en_q;

    // global register read data
    reg [31:0] glob_rdata;
    always @* begin
        glob_rdata = 32'h0;
        case (adr_i)
            `OFF_INT_STATUS: glob_rdata = {31'h0, done_status_q};
            `OFF_INT_ENABLE: glob_rdata = {31'h0, irq_en_q};
            `OFF_LAST_OUT: glob_rdata = {28'h0, hist_q[wr_dec]}; // [R16]
            `OFF_HIST_GET: glob_rdata = {22'h0, ovf_q, match_q, 4'h0,
                hist_q[rd_ptr_q]}; // [R18]
            `OFF_ABT_CTRL: glob_rdata = {30'h0, abt_trig_q, abt_mode_q};
            `OFF_TX_STATE: glob_rdata = {26'h0, state_q, cur_q};
            default: glob_rdata = 32'h0;
        endcase
    end

    // read mux
    reg [31:0] rdata;
    always @* begin
        rdata = 32'h0;
        case (grp)
            2'h0: rdata = {26'h0, cfg_q[idx]};
            2'h1: rdata = {3'h0, id_q[idx]};
            2'h2: rdata = {29'h0, ctrl_q[idx]};
            default: rdata = glob_rdata;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            dat_o <= rd ? rdata : 32'h0;
        end
    end

    // buffer registers and request handling
    integer b;
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (b = 0; b < 16; b = b + 1) begin
                cfg_q[b] <= 6'h0;
                id_q[b] <= 29'h0;
                ctrl_q[b] <= 3'h0;
            end
        end else begin
            if (wr_cfg)
                cfg_q[idx] <= dat_i[5:0];
            if (wr_id)
                id_q[idx] <= dat_i[28:0];
            // ready may be held while the buffer is on the wire [R13]
            if (wr_ctrl) begin
                if (ctrl_hold)
                    ctrl_q[idx] <= {dat_i[2], 1'b1, dat_i[0]};
                else
                    ctrl_q[idx] <= dat_i[2:0];
            end
            // block trigger sets request of one buffer only [R9]
            if (abt_set)
                ctrl_q[abt_ptr_q][`CTRL_TRQ] <= 1'b1;
            if (success)
                ctrl_q[cur_q][`CTRL_TRQ] <= 1'b0; // [R10]
        end
    end

    // search and transmit sequencing
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            cur_q <= 4'h0;
            tx_start_o <= 1'b0;
            tx_buf_o <= 4'h0;
            tx_id_o <= 29'h0;
            tx_ide_o <= 1'b0;
            tx_rtr_o <= 1'b0;
        end else begin
            tx_start_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (|cand)
                        state_q <= ST_SEARCH;
                end
                ST_SEARCH: begin
                    // fresh search each time picks newest winner [R2] [R3]
                    if (best_ok) begin
                        cur_q <= best_buf;
                        tx_buf_o <= best_buf;
                        tx_id_o <= id_q[best_buf];
                        tx_ide_o <= cfg_q[best_buf][`CFG_IDE];
                        tx_rtr_o <= cfg_q[best_buf][`CFG_RTR];
                        tx_start_o <= 1'b1;
                        state_q <= ST_BUSY;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_BUSY: begin
                    // started frame runs to its end [R3]
                    if (tx_done_i || tx_abort_i)
                        state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // completion status, interrupt, block mode control
    always @(posedge clk_i) begin
        if (rst_i) begin
            done_status_q <= 1'b0;
            irq_en_q <= 1'b0;
            tx_done_irq_o <= 1'b0;
            abt_mode_q <= 1'b0;
            abt_trig_q <= 1'b0;
            abt_ptr_q <= 3'h0;
        end else begin
            tx_done_irq_o <= irq_fire; // [R12]
            if (wr_status && dat_i[0])
                done_status_q <= 1'b0;
            // set wins over a clear in the same cycle
            if (success && cur_ie)
                done_status_q <= 1'b1; // [R11]
            if (wr_ienable)
                irq_en_q <= dat_i[0];
            if (wr_abt) begin
                abt_mode_q <= dat_i[`ABT_MODE];
                abt_trig_q <= dat_i[`ABT_TRIG];
            end
            if (success && cur_abt) begin
                abt_ptr_q <= abt_ptr_q + 3'h1;
                if (cur_q == `ABT_LAST)
                    abt_trig_q <= 1'b0;
            end
        end
    end

    // history list; contents left unreset [R15]
    always @(posedge clk_i) begin
        if (record)
            hist_q[hist_wa] <= cur_q; // [R14] [R17]
    end

    // history pointer and flag next values
    reg [2:0] wr_ptr_d;
    reg [2:0] rd_ptr_d;
    reg match_d;
    reg ovf_d;
    always @* begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        match_d = match_q;
        ovf_d = ovf_q;
        if (ovf_clr)
            ovf_d = 1'b0; // [R21]
        // full list stops advancing; match kept while overflowed [R20] [R21]
        if (record && !ovf_q) begin
            wr_ptr_d = wr_inc; // [R17]
            match_d = 1'b0; // [R19]
            if (wr_inc == rd_dec)
                ovf_d = 1'b1; // [R20]
        end
        if (get_rd && !match_q) begin
            rd_ptr_d = rd_inc; // [R18]
            match_d = (rd_inc == wr_ptr_d); // [R19]
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_q <= `PTR_RESET;
            rd_ptr_q <= `PTR_RESET;
            match_q <= 1'b1;
            ovf_q <= 1'b0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            match_q <= match_d;
            ovf_q <= ovf_d;
        end
    end

endmodule

//--- include/can_tx_defs.vh
// can_tx_defs.vh: register offsets, field positions, reset values for the tx block
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef CAN_TX_DEFS_VH
`define CAN_TX_DEFS_VH

`define NUM_BUF 16
`define HIST_DEPTH 7
`define ABT_LAST 4'h7

// per-buffer registers: base + 4*buffer
`define OFF_CFG_BASE 8'h00
`define OFF_ID_BASE 8'h40
`define OFF_CTRL_BASE 8'h80
// global registers
`define OFF_INT_STATUS 8'hC0
`define OFF_INT_ENABLE 8'hC4
`define OFF_LAST_OUT 8'hC8
`define OFF_HIST_GET 8'hCC
`define OFF_ABT_CTRL 8'hD0
`define OFF_TX_STATE 8'hD4

// config register fields
`define CFG_IN_USE 0
`define CFG_TYPE_LO 1
`define CFG_TYPE_HI 3
`define CFG_RTR 4
`define CFG_IDE 5
`define TYPE_TX 3'h0

// control register fields
`define CTRL_TRQ 0
`define CTRL_RDY 1
`define CTRL_IE 2

// history get register fields
`define GET_MATCH 8
`define GET_OVF 9

// abt control field
`define ABT_MODE 0
`define ABT_TRIG 1

`define PTR_RESET 3'h0

`endif

//--- dv/can_tx_priority_history_sva.sv
// checker: bus slave and tx link timing at the block's ports
// assumes one clock with synchronous active-high reset
`timescale 1ns/100ps
module can_tx_sva (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire tx_start_o,
    input wire [3:0] tx_buf_o,
    input wire tx_done_i,
    input wire tx_done_irq_o
);
    reg busy_q;
    always @(posedge clk_i) begin
        busy_q <= rst_i ? 1'b0 : tx_start_o ? 1'b1 : tx_done_i ? 1'b0 : busy_q;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    chk_ack_once: assert property (ack_o |=> !ack_o) else $error("long ack");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
    chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data no ack");
    chk_start_idle: assert property (tx_start_o |-> !busy_q) else $error("busy start");
    chk_start_once: assert property (tx_start_o |=> !tx_start_o) else $error("long start");
    chk_buf_held: assert property (!tx_start_o |-> $stable(tx_buf_o)) else $error("buf moved");
    chk_irq_cause: assert property (tx_done_irq_o |-> $past(tx_done_i && busy_q))
        else $error("stray irq");
    chk_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !ack_o && !tx_start_o && !tx_done_irq_o) else $error("active in reset");
    cv_start: cover property (tx_start_o);
    cv_irq: cover property (tx_done_irq_o);
    cv_ovf: cover property (ack_o && dat_o[9]);
endmodule

bind can_tx_priority_history can_tx_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .tx_start_o(tx_start_o),
    .tx_buf_o(tx_buf_o), .tx_done_i(tx_done_i), .tx_done_irq_o(tx_done_irq_o));

//--- dv/can_bus_model.sv
// can_bus_model: far-side engine, reports each frame sent delay_i+1 cycles after it samples the start
// assumes one start at a time; it never aborts
`timescale 1ns/100ps
module can_bus_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] delay_i,
    output logic done_o
);
    logic [7:0] cnt_q;
    logic busy_q;
    always @(posedge clk_i) begin
        done_o <= busy_q && cnt_q == 8'h00;
        busy_q <= !rst_i && (start_i || (busy_q && cnt_q != 8'h00));
        cnt_q <= start_i ? delay_i : cnt_q - 8'h01;
    end
endmodule

//--- dv/tb_can_tx_priority_history.sv
// tb: random priority rounds, block mode and history overflow
// assumes the engine model answers each start delay_q+1 cycles after it samples it
`timescale 1ns/100ps
`include "can_tx_defs.vh"
module tb_can_tx_priority_history;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [7:0] delay_q = 8'h3C;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, rd;
    logic ack_o, tx_start_o, tx_ide_o, tx_rtr_o, tx_done_i, irq;
    logic [3:0] tx_buf_o;
    logic [28:0] tx_id_o;
    logic [3:0] sent_q[$];
    logic [30:0] fr_q[$];
    int error_cnt = 0;
    int checked = 0;
    int irq_n = 0;
    int done_n = 0;
    initial forever #10 clk_i = ~clk_i;
    can_tx_priority_history u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .tx_start_o(tx_start_o), .tx_buf_o(tx_buf_o), .tx_id_o(tx_id_o), .tx_ide_o(tx_ide_o),
        .tx_rtr_o(tx_rtr_o), .tx_done_i(tx_done_i), .tx_abort_i(1'b0), .tx_done_irq_o(irq));
    can_bus_model u_bus (.clk_i(clk_i), .rst_i(rst_i), .start_i(tx_start_o),
        .delay_i(delay_q), .done_o(tx_done_i));
    always @(posedge clk_i) begin
        if (tx_start_o === 1'b1) begin
            sent_q.push_back(tx_buf_o);
            fr_q.push_back({tx_ide_o, tx_rtr_o, tx_id_o});
        end
        if (irq === 1'b1) irq_n++;
        if (tx_done_i === 1'b1) done_n++;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) error_cnt++;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checked++;
        if ((got & m) !== (exp & m)) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got & m, exp & m);
        end
    endtask
    task automatic wait_n(input int n);
        for (int c = 0; c < 3000 && done_n < n; c++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
    endtask
    function automatic logic [34:0] key(input logic [28:0] id, input logic [5:0] c,
        input logic [3:0] b);
        return {id[28:18], c[5], c[4], c[5] ? id[17:0] : 18'h0, b};
    endfunction
    task automatic round(input int r, input logic ge);
        logic [34:0] k[$];
        logic [34:0] k0;
        logic [30:0] f[5];
        int x;
        logic [31:0] c[5];
        logic [31:0] ct;
        logic [28:0] id;
        logic [3:0] b;
        int ie = 0;
        int n0 = irq_n;
        int d0 = done_n;
        sent_q = {};
        fr_q = {};
        bus(1'b1, `OFF_INT_ENABLE, {31'h0, ge});
        for (int j = 0; j < 5; j++) begin
            b = 4'(r * 5 + j);
            if (j < 4) begin
                id = 29'($urandom) & 29'h00C0003;
                c[j] = ($urandom & 32'h30) | 32'h1;
            end else c[j] = c[3];
            ct = 32'h3 | ($urandom & 32'h4);
            ie += int'(ct[2]);
            bus(1'b1, `OFF_CTRL_BASE + {b, 2'b00}, 32'h0);
            bus(1'b1, `OFF_CFG_BASE + {b, 2'b00}, c[j] & 32'hFFFFFFFE);
            bus(1'b1, `OFF_ID_BASE + {b, 2'b00}, {3'h0, id});
            bus(1'b1, `OFF_CTRL_BASE + {b, 2'b00}, ct);
            f[j] = {c[j][5], c[j][4], id};
            k.push_back(key(id, c[j][5:0], b));
        end
        for (int j = 0; j < 5; j++) begin
            bus(1'b1, `OFF_CFG_BASE + {k[j][3:0], 2'b00}, c[j]);
            for (int w = 0; w < 50 && sent_q.size() == 0; w++) @(posedge clk_i);
        end
        wait_n(d0 + 5);
        k0 = k.pop_front();
        k.sort();
        k.push_front(k0);
        for (int j = 0; j < 5; j++) begin
            cmp({28'h0, sent_q[j]}, {28'h0, k[j][3:0]}, 32'hF);
            x = int'(k[j][3:0]) - r * 5;
            cmp({1'b0, fr_q[j]}, {1'b0, f[x]}, 32'h7FFFFFFF);
            bus(1'b0, `OFF_HIST_GET, 32'h0);
            cmp(rd, {28'h0, k[j][3:0]}, 32'h30F);
        end
        bus(1'b0, `OFF_HIST_GET, 32'h0);
        cmp(rd, 32'h100, 32'h300);
        bus(1'b0, `OFF_LAST_OUT, 32'h0);
        cmp(rd, {28'h0, k[4][3:0]}, 32'hF);
        bus(1'b0, `OFF_CTRL_BASE + {k[0][3:0], 2'b00}, 32'h0);
        cmp(rd, 32'h0, 32'h1);
        bus(1'b0, `OFF_INT_STATUS, 32'h0);
        cmp(rd, {31'h0, ie != 0}, 32'h1);
        bus(1'b1, `OFF_INT_STATUS, 32'h1);
        cmp(32'(irq_n - n0), ge ? 32'(ie) : 32'h0, 32'hFF);
        $display("round %0d done", r);
    endtask
    task automatic complete_run();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12000) @(posedge clk_i);
        error_cnt++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h2AB4));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, `OFF_HIST_GET, 32'h0);
        cmp(rd, 32'h100, 32'h300);
        bus(1'b0, 8'hFC, 32'h0);
        cmp(rd, 32'h0, 32'hFFFFFFFF);
        for (int r = 0; r < 3; r++) round(r, r != 1);
        for (int j = 0; j < 8; j++) begin
            bus(1'b1, `OFF_CFG_BASE + 8'(4 * j), 32'h1);
            bus(1'b1, `OFF_CTRL_BASE + 8'(4 * j), 32'h2);
        end
        sent_q = {};
        bus(1'b1, `OFF_ABT_CTRL, 32'h3);
        wait_n(done_n + 8);
        for (int j = 0; j < 8; j++) cmp({28'h0, sent_q[j]}, 32'(j), 32'hF);
        bus(1'b0, `OFF_HIST_GET, 32'h0);
        cmp(rd, 32'h100, 32'h300);
        bus(1'b1, `OFF_ABT_CTRL, 32'h0);
        $display("block test done");
        delay_q <= 8'h02;
        bus(1'b1, `OFF_CFG_BASE + 8'h3C, 32'h1);
        for (int j = 0; j < 9; j++) begin
            bus(1'b1, `OFF_CTRL_BASE + 8'h3C, 32'h3);
            wait_n(done_n + 1);
            if (j == 7) for (int i = 0; i < 7; i++) begin
                bus(1'b0, `OFF_HIST_GET, 32'h0);
                cmp(rd, i < 6 ? 32'h20F : 32'h300, i < 6 ? 32'h30F : 32'h300);
            end
        end
        bus(1'b0, `OFF_HIST_GET, 32'h0);
        cmp(rd, 32'h300, 32'h300);
        bus(1'b1, `OFF_HIST_GET, 32'h0);
        bus(1'b0, `OFF_HIST_GET, 32'h0);
        cmp(rd, 32'h0, 32'h200);
        $display("history test done");
        complete_run();
    end
endmodule
